//--- design/pmicr_pkg.sv
// Register map constants for the power-manager register block
package pmicr_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] A_GEN1   = 8'h01; // Shutdown delay, start order
   localparam logic [7:0] A_GEN2   = 8'h02; // Group enables, all off
   localparam logic [7:0] A_GEN3   = 8'h03; // Status and strapped fields
   localparam logic [7:0] A_VG1    = 8'h04; // Gate supply settings
   localparam logic [7:0] A_F1     = 8'h05; // Gate supply fault_summary
   localparam logic [7:0] A_F2     = 8'h07; // Regulator 2 fault_summary
   localparam logic [7:0] A_F3     = 8'h09; // Regulator 3 fault_summary
   localparam logic [7:0] A_F4     = 8'h0b; // Regulator 4 fault_summary
   localparam logic [7:0] A_R5SS   = 8'h0d; // Regulator 5 ramp time
   localparam logic [7:0] A_F5     = 8'h0e; // Regulator 5 fault_summary
   localparam logic [7:0] A_R6S    = 8'h0f; // Regulator 6 settings
   localparam logic [7:0] A_R6SS   = 8'h10; // Regulator 6 ramp time
   localparam logic [7:0] A_F6     = 8'h11; // Regulator 6 fault_summary
   localparam logic [7:0] A_R7S    = 8'h12; // Regulator 7 settings
   localparam logic [7:0] A_R7SS   = 8'h13; // Regulator 7 rate and ramp
   localparam logic [7:0] A_F7     = 8'h14; // Regulator 7 fault_summary
   localparam logic [7:0] A_R8M    = 8'h16; // Regulator 8 current and mode
   localparam logic [7:0] A_F8     = 8'h17; // Regulator 8 fault_summary
   localparam logic [7:0] A_FSUM   = 8'h18; // Fault summary
   localparam logic [7:0] A_BUS    = 8'h19; // Bus settings
   localparam logic [7:0] A_TRIM3  = 8'h49; // Regulator 3 fine trim
   localparam logic [7:0] A_R7EN   = 8'h58; // Regulator 7 enable control
   localparam logic [7:0] A_R7TRIM = 8'h59; // Regulator 7 level trim
   localparam int         NSTORE   = 26;    // Stored bytes 0x00 to 0x19
   // ----------------------------------------------------------------
   // Field masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] M_GEN1   = 8'h0f; // shutdown_delay_sel, startup_order_sel
   localparam logic [7:0] M_GEN2A  = 8'h1f; // turn_everything_off, four groups
   localparam logic [7:0] M_GEN2B  = 8'h13; // Five-regulator group set
   localparam logic [7:0] M_SET    = 8'h1f; // voltage_step_target, window_limit_sel
   localparam logic [7:0] M_SS     = 8'h03; // ramp_time_override
   localparam logic [7:0] M_R7SSB  = 8'h0c; // Rate field only, five-regulator
   localparam logic [7:0] M_R8M    = 8'h7f; // Current step, loop select, ramp
   localparam logic [7:0] M_BUS    = 8'h01; // Bus accuracy bit
   localparam logic [7:0] M_F7     = 8'h07; // Regulator 7 has no heat/short/limit
   localparam logic [7:0] M_F1B    = 8'h06; // Gate supply fault_summary, five-regulator
   localparam logic [7:0] M_FSUMB  = 8'h9f; // Summary bits, five-regulator
   localparam logic [7:0] R8M_RST  = 8'h78; // Full current, current loop
   localparam int         CELL_BIT = 2;     // cell_kind_sel in status byte
   localparam int         COLD_BIT = 3;     // battery_insert_flag in status byte
   localparam int         LOOP_BIT = 2;     // backlight_loop_sel
   localparam logic [3:0] NO_FLT   = 4'hf;  // Not a fault register
   // ----------------------------------------------------------------
   // Strap decode thresholds in 32nds of the core supply
   // ----------------------------------------------------------------
   localparam logic [4:0] RT_1000 = 5'h09;
   localparam logic [4:0] RT_1250 = 5'h0d;
   localparam logic [4:0] RT_1500 = 5'h11;
   localparam logic [4:0] RT_1750 = 5'h15;
   localparam logic [4:0] RT_2000 = 5'h19;
   localparam logic [4:0] SS_2MS  = 5'h0b;
   localparam logic [4:0] SS_8MS  = 5'h13;
   localparam logic [4:0] SS_32MS = 5'h1b;
   // Primary rate codes: 750, 1000, 1250, 1500, 1750, 2000 kHz
   typedef enum logic [2:0] {
      PMICR_750, PMICR_1000, PMICR_1250, PMICR_1500, PMICR_1750, PMICR_2000
   } pmicr_rate_t;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 40;    // System clock
   localparam int STRAP_SETTLE_NS = 10000; // Strap settle before sampling
   localparam int STRAP_CYC      = (STRAP_SETTLE_NS * CLK_MHZ) / 1000;
endpackage

//--- design/pmicr_regmap.sv
// Two-wire register map with strap capture and fault latching
// Notes on behaviour
// - Per-regulator fault bits plus voltage step done
// - Summary register, one flag per regulator
// - Fault bytes read-only, status byte takes only cell bit and flag clear; regulator 3 trim and regulator 7 enable/trim lie outside 0x00-0x19
// - Unconnected rate strap starts at 750 kHz
// - Rate strap fraction decodes to six rates
// - Rate strap sampled once at startup only
// - Ramp strap decoded once to four times
// - Five-regulator variant reserves absent regulators
// - Strapped ramp copied into regulators 5-8
// - Battery flag sampled with the straps, host clears
// - Loop select defaults to current regulation
`timescale 1ns/1ps
module pmicr_regmap
   import pmicr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR  = 7'h2a, // Bus address
   parameter bit         EIGHT_REG = 1'b1   // Eight-regulator variant
) (
   input  wire logic                clock,
   input  wire logic                reset,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe,
   input  wire logic                rate_strap_open,
   input  wire logic [4:0]          rate_strap_input,
   input  wire logic [4:0]          ramp_strap_code,
   input  wire logic                battery_insert_in,
   input  wire logic                power_down_in,
   input  wire logic [39:0]         fault_in,
   input  wire logic [7:0]          step_done_in,
   output logic [NSTORE*8-1:0]      cfg_image,
   output logic [7:0]               trim3_out,
   output logic [7:0]               r7_enable_out,
   output logic [7:0]               r7_trim_out,
   output logic [2:0]               primary_switch_rate,
   output logic [1:0]               strapped_ramp_time,
   output logic                     strap_done
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 63;
   logic [SW-1:0] sync1_r;             // First stage, read only by second
   logic [SW-1:0] sync2_r;             // Safe copy
   logic          scl_p_r;             // Delayed clock line
   logic          sda_p_r;             // Delayed data line

   // Two flops for every pin input
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync1_r <= '0;
         sync2_r <= '0;
         // Bus lines rest high so no false edge follows reset
         sync1_r[62:61] <= 2'h3;
         sync2_r[62:61] <= 2'h3;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end else begin
         sync1_r <= {scl_in, sda_in, rate_strap_open, rate_strap_input,
                     ramp_strap_code, battery_insert_in, power_down_in,
                     fault_in, step_done_in};
         sync2_r <= sync1_r;
         scl_p_r <= sync2_r[62];
         sda_p_r <= sync2_r[61];
      end
   end

   wire       scl_s  = sync2_r[62];
   wire       sda_s  = sync2_r[61];
   wire       open_s = sync2_r[60];
   wire [4:0] rate_s = sync2_r[59:55];
   wire [4:0] ramp_s = sync2_r[54:50];
   wire       bat_s  = sync2_r[49];
   wire       pd_s   = sync2_r[48];
   wire [39:0] flt_s = sync2_r[47:8];
   wire [7:0] done_s = sync2_r[7:0];

   wire scl_rise = scl_s & ~scl_p_r;
   wire scl_fall = ~scl_s & scl_p_r;
   wire bus_start = scl_s & scl_p_r & ~sda_s & sda_p_r;
   wire bus_stop  = scl_s & scl_p_r & sda_s & ~sda_p_r;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Writable bits of a stored byte; zero means read-only or reserved
   function automatic logic [7:0] wr_mask(input logic [7:0] a);
      logic [7:0] m;
      m = 8'h00;
      case (a)
         A_GEN1: m = M_GEN1;
         A_GEN2: m = EIGHT_REG ? M_GEN2A : M_GEN2B;
         A_VG1, A_R6S, A_R7S: m = EIGHT_REG ? M_SET : 8'h00;
         8'h06, 8'h08, 8'h0a, 8'h0c, 8'h15: m = M_SET;
         A_R5SS: m = M_SS;
         A_R6SS: m = EIGHT_REG ? M_SS : 8'h00;
         A_R7SS: m = EIGHT_REG ? M_SS | M_R7SSB : M_R7SSB;
         A_R8M:  m = M_R8M;
         A_BUS:  m = M_BUS;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Fault register address to regulator index
   function automatic logic [3:0] flt_idx(input logic [7:0] a);
      logic [3:0] i;
      i = NO_FLT;
      case (a)
         A_F1: i = 4'h0;
         A_F2: i = 4'h1;
         A_F3: i = 4'h2;
         A_F4: i = 4'h3;
         A_F5: i = 4'h4;
         A_F6: i = 4'h5;
         A_F7: i = 4'h6;
         A_F8: i = 4'h7;
         default: i = NO_FLT;
      endcase
      return i;
   endfunction

   // Fraction decode to a threshold band
   function automatic logic [2:0] band(input logic [4:0] c,
                                       input logic [4:0] t1,
                                       input logic [4:0] t2,
                                       input logic [4:0] t3,
                                       input logic [4:0] t4,
                                       input logic [4:0] t5);
      logic [2:0] b;
      b = 3'h0;
      if (c >= t1) b = 3'h1;
      if (c >= t2) b = 3'h2;
      if (c >= t3) b = 3'h3;
      if (c >= t4) b = 3'h4;
      if (c >= t5) b = 3'h5;
      return b;
   endfunction

   // Ramp strap fraction to the two-bit ramp code
   function automatic logic [1:0] ramp_dec(input logic [4:0] c);
      return c >= SS_32MS ? 2'h3 : c >= SS_8MS ? 2'h2 : c >= SS_2MS ? 2'h1 : 2'h0;
   endfunction

   // ----------------------------------------------------------------
   // Strap capture after reset release
   // ----------------------------------------------------------------
   logic [15:0] settle_r;              // Settle counter
   logic        strap_done_r;          // Straps captured
   logic [2:0]  rate_r;                // Primary rate code
   logic [1:0]  ramp_r;                // Strapped ramp time
   wire         strap_fire = ~strap_done_r && (settle_r == 16'(STRAP_CYC - 1));

   // Settle counter, stops once the straps are taken
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         settle_r     <= 16'h0000;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         settle_r     <= settle_r + 16'h0001;
         strap_done_r <= strap_fire;
      end
   end

   // Straps sampled once; later changes ignored
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rate_r <= PMICR_750;
         ramp_r <= 2'h0;
      end else if (strap_fire) begin
         // Floating input falls back to the slowest rate
         rate_r <= open_s ? PMICR_750 :
                   band(rate_s, RT_1000, RT_1250, RT_1500,
                        RT_1750, RT_2000);
         ramp_r <= ramp_dec(ramp_s);
      end
   end

   // ----------------------------------------------------------------
   // Bus slave state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PMICR_IDLE, PMICR_ADDR, PMICR_ACK, PMICR_WIDX,
      PMICR_WDATA, PMICR_RDATA, PMICR_MACK, PMICR_RLOAD
   } pmicr_bus_t;
   pmicr_bus_t  st_r;                  // Slave state
   logic [3:0]  cnt_r;                 // Bit counter
   logic [7:0]  shift_r;               // Incoming byte
   logic [7:0]  tx_r;                  // Outgoing byte
   logic [7:0]  ptr_r;                 // Register pointer
   logic        rw_r;                  // Read transfer
   logic        idx_ok_r;              // Pointer byte received
   logic        sda_oe_r;              // Pulling data low
   logic        sda_out_r;             // Driven level, always low
   logic [7:0]  rd_data;               // Read mux
   logic [NSTORE-1:0][7:0] store_r;    // Writable bytes
   logic [7:0]  trim3_r;               // Regulator 3 fine trim
   logic [7:0]  r7en_r;                // Regulator 7 enable control
   logic [7:0]  r7trim_r;              // Regulator 7 level trim
   logic [7:0][4:0] flt_r;             // Latched fault_summary per regulator

   wire rd_load  = scl_fall && ((st_r == PMICR_ACK && rw_r) || st_r == PMICR_RLOAD);
   wire wr_fire  = scl_fall && st_r == PMICR_WDATA && cnt_r == 4'h8;
   wire [3:0] rd_fi = flt_idx(ptr_r);

   // Summary: one flag per regulator, 8 in the top bit
   logic [7:0] fsum;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         fsum[i] = |flt_r[i];
      end
      if (!EIGHT_REG) begin
         fsum = fsum & M_FSUMB;
      end
   end

   // Read mux; unmapped addresses and unused bits read zero
   always_comb begin
      rd_data = 8'h00;
      if (rd_fi != NO_FLT) begin
         rd_data = {2'h0, flt_r[rd_fi], done_s[rd_fi[2:0]]};
         if (rd_fi == 4'h6) rd_data = rd_data & M_F7;
         if (!EIGHT_REG && rd_fi == 4'h0) rd_data = rd_data & M_F1B;
         if (!EIGHT_REG && (rd_fi == 4'h5 || rd_fi == 4'h6)) rd_data = 8'h00;
      end else if (ptr_r == A_GEN3) begin
         rd_data = {3'h0, pd_s, store_r[A_GEN3][COLD_BIT:CELL_BIT], ramp_r};
      end else if (ptr_r == A_FSUM) begin
         rd_data = fsum;
      end else if (ptr_r == A_TRIM3) begin
         rd_data = trim3_r;
      end else if (EIGHT_REG && ptr_r == A_R7EN) begin
         rd_data = r7en_r;
      end else if (EIGHT_REG && ptr_r == A_R7TRIM) begin
         rd_data = r7trim_r;
      end else if (ptr_r < 8'(NSTORE)) begin
         rd_data = store_r[ptr_r[4:0]] & wr_mask(ptr_r);
      end
   end

   // Two-wire slave sequencing
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_r     <= PMICR_IDLE;
         cnt_r    <= 4'h0;
         shift_r  <= 8'h00;
         tx_r     <= 8'h00;
         ptr_r    <= 8'h00;
         rw_r     <= 1'b0;
         idx_ok_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (bus_start) begin
         // Start or repeated start
         st_r     <= PMICR_ADDR;
         cnt_r    <= 4'h0;
         idx_ok_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
         st_r     <= PMICR_IDLE;
         sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
         case (st_r)
            PMICR_ADDR, PMICR_WIDX, PMICR_WDATA: begin
               shift_r <= {shift_r[6:0], sda_s};
               cnt_r   <= cnt_r + 4'h1;
            end
            PMICR_MACK: begin
               // High means the host refuses further bytes
               st_r <= sda_s ? PMICR_IDLE : PMICR_RLOAD;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st_r)
            PMICR_ADDR: begin
               if (cnt_r == 4'h8) begin
                  if (shift_r[7:1] == DEV_ADDR) begin
                     sda_oe_r <= 1'b1;
                     rw_r     <= shift_r[0];
                     st_r     <= PMICR_ACK;
                  end else begin
                     st_r <= PMICR_IDLE;
                  end
               end
            end
            PMICR_WIDX: begin
               if (cnt_r == 4'h8) begin
                  ptr_r    <= shift_r;
                  idx_ok_r <= 1'b1;
                  sda_oe_r <= 1'b1;
                  st_r     <= PMICR_ACK;
               end
            end
            PMICR_WDATA: begin
               if (cnt_r == 4'h8) begin
                  ptr_r    <= ptr_r + 8'h01;
                  sda_oe_r <= 1'b1;
                  st_r     <= PMICR_ACK;
               end
            end
            PMICR_ACK, PMICR_RLOAD: begin
               cnt_r <= 4'h0;
               if (rd_load) begin
                  tx_r     <= rd_data;
                  sda_oe_r <= ~rd_data[7];
                  st_r     <= PMICR_RDATA;
               end else begin
                  sda_oe_r <= 1'b0;
                  st_r     <= idx_ok_r ? PMICR_WDATA : PMICR_WIDX;
               end
            end
            PMICR_RDATA: begin
               if (cnt_r == 4'h7) begin
                  sda_oe_r <= 1'b0;
                  ptr_r    <= ptr_r + 8'h01;
                  st_r     <= PMICR_MACK;
               end else begin
                  cnt_r    <= cnt_r + 4'h1;
                  tx_r     <= {tx_r[6:0], 1'b0};
                  sda_oe_r <= ~tx_r[6];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   // Host writes through the field mask; strap copy lands first
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         store_r        <= '0;
         store_r[A_R8M] <= R8M_RST;
      end else begin
         if (strap_fire) begin
            store_r[A_R5SS][1:0] <= ramp_dec(ramp_s);
            store_r[A_R6SS][1:0] <= ramp_dec(ramp_s);
            store_r[A_R7SS][1:0] <= ramp_dec(ramp_s);
            store_r[A_R8M][1:0]  <= ramp_dec(ramp_s);
         end
         if (wr_fire && ptr_r == A_GEN3) begin
            store_r[A_GEN3][CELL_BIT] <= shift_r[CELL_BIT];
            // Zero clears the battery flag; one leaves it alone
            if (!shift_r[COLD_BIT]) store_r[A_GEN3][COLD_BIT] <= 1'b0;
         end else if (wr_fire && ptr_r < 8'(NSTORE)) begin
            store_r[ptr_r[4:0]] <= (store_r[ptr_r[4:0]] & ~wr_mask(ptr_r)) |
                                   (shift_r & wr_mask(ptr_r));
         end
         // Battery flag taken with the straps; beats a clear in the same cycle
         if (strap_fire) store_r[A_GEN3][COLD_BIT] <= bat_s;
      end
   end

   // Special registers outside the main block
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         trim3_r  <= 8'h00;
         r7en_r   <= 8'h00;
         r7trim_r <= 8'h00;
      end else if (wr_fire) begin
         if (ptr_r == A_TRIM3) trim3_r <= shift_r;
         if (EIGHT_REG && ptr_r == A_R7EN) r7en_r <= shift_r;
         if (EIGHT_REG && ptr_r == A_R7TRIM) r7trim_r <= shift_r;
      end
   end

   // Fault_summary latch until their register is read; a new fault wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flt_r <= '0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            flt_r[i] <= ((rd_load && rd_fi == 4'(i)) ? 5'h00 : flt_r[i]) |
                        flt_s[i*5 +: 5];
         end
      end
   end

   // Driven data level is always low
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from flops
   // ----------------------------------------------------------------
   assign sda_out             = sda_out_r;
   assign sda_oe              = sda_oe_r;
   assign cfg_image           = store_r;
   assign trim3_out           = trim3_r;
   assign r7_enable_out       = r7en_r;
   assign r7_trim_out         = r7trim_r;
   assign primary_switch_rate = rate_r;
   assign strapped_ramp_time  = ramp_r;
   assign strap_done          = strap_done_r;
endmodule

//--- verification/pmicr_host.sv
// Two-wire bus host model that drives the register block's clock and data lines
`timescale 1ns/1ps
module pmicr_host (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      md
);
   // Both lines idle released, pulled high
   initial begin
      scl = 1'b1;
      md  = 1'b1;
   end
   // Half bit: eight clocks, above the six-clock minimum, then off the edge
   task automatic hb;
      repeat (8) @(posedge clock);
      #1;
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start;
      md = 1'b1;
      hb;
      scl = 1'b1;
      hb;
      md = 1'b0;
      hb;
      scl = 1'b0;
      hb;
   endtask
   // Stop: data rises while the clock is high
   task automatic stop;
      md = 1'b0;
      hb;
      scl = 1'b1;
      hb;
      md = 1'b1;
      hb;
   endtask
   // One bit; data moves only while the clock is low
   task automatic bt(input logic b, output logic r);
      md = b;
      hb;
      scl = 1'b1;
      hb;
      r = sda;
      scl = 1'b0;
      hb;
   endtask
   // Byte out, most significant bit first, then the device's acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
      ack = ~r;
   endtask
   // Byte in; a last byte is refused so the device ends the read
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
      bt(last, r);
   endtask
endmodule

//--- verification/pmicr_regmap_bench.sv
// Self-checking bench for the register block through its two-wire bus
`timescale 1ns/1ps
module pmicr_regmap_bench;
   import pmicr_pkg::*;
   logic        clock, reset, scl, md, sda, sda_out, sda_oe, rate_open, batt, done;
   logic [4:0]  rate_in, ramp_in;
   logic [39:0] fault;
   logic [7:0]  step, trim, r7en, r7tr;
   logic [2:0]  rate;
   logic [1:0]  ramp;
   int          n_mismatch = 0, checked = 0, cyc = 0;
   logic [4:0]  rt[6] = '{5'h00, 5'h09, 5'h0d, 5'h11, 5'h15, 5'h1f}; // Band edges
   logic [4:0]  rp[4] = '{5'h00, 5'h0b, 5'h13, 5'h1f};
   logic [7:0]  fa[8] = '{8'h05, 8'h07, 8'h09, 8'h0b, 8'h0e, 8'h11, 8'h14, 8'h17};
   logic [7:0]  ua[4] = '{8'h00, 8'h17, 8'h18, 8'h30}; // Read-only, reserved, unmapped
   assign sda = md & (sda_oe ? sda_out : 1'b1); // Open drain with pull-up
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   pmicr_host u_host (.clock(clock), .sda(sda), .scl(scl), .md(md));
   pmicr_regmap u_dut (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .rate_strap_open(rate_open),
      .rate_strap_input(rate_in), .ramp_strap_code(ramp_in), .battery_insert_in(batt),
      .power_down_in(1'b0), .fault_in(fault), .step_done_in(step), .cfg_image(),
      .trim3_out(trim), .r7_enable_out(r7en), .r7_trim_out(r7tr), .primary_switch_rate(rate),
      .strapped_ramp_time(ramp), .strap_done(done));
   task automatic stop_test;
      $display("counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // Reset for five clocks, then wait for the strap capture
   task automatic boot;
      reset = 1'b1;
      repeat (5) @(posedge clock);
      #1 reset = 1'b0;
      for (int i = 0; i < 500 && done !== 1'b1; i++) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k;
      u_host.start;
      u_host.wbyte(8'h54, k);
      u_host.wbyte(a, k);
      u_host.wbyte(d, k);
      u_host.stop;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic k;
      logic [7:0] v;
      u_host.start;
      u_host.wbyte(8'h54, k);
      u_host.wbyte(a, k);
      u_host.start;
      u_host.wbyte(8'h55, k);
      u_host.rbyte(1'b1, v);
      u_host.stop;
      chk(v, e);
   endtask
   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         n_mismatch++;
         stop_test;
      end
   end
   initial begin
      reset = 1'b1; rate_open = 1'b1; rate_in = 5'h1f; ramp_in = 5'h00;
      batt = 1'b1; fault = '0; step = 8'h00;
      boot;
      chk({5'h0, rate}, 8'h00);
      rate_open = 1'b0;
      for (int i = 0; i < 6; i++) begin
         rate_in = rt[i];
         ramp_in = rp[i % 4];
         boot;
         chk({5'h0, rate}, 8'(i));
         chk({6'h0, ramp}, 8'(i % 4));
      end
      $display("test straps done");
      rd(8'h03, 8'h09);
      rd(8'h0d, 8'h01);
      rd(8'h16, 8'h79);
      rate_in = 5'h00;
      wr(8'h03, 8'h00);
      rd(8'h03, 8'h01);
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h05);
      chk({5'h0, rate}, 8'h05);
      wr(8'h0d, 8'h03);
      rd(8'h0d, 8'h03);
      wr(8'h16, 8'h04);
      rd(8'h16, 8'h04);
      wr(8'h49, 8'h5a);
      rd(8'h49, 8'h5a);
      wr(8'h58, 8'hd0);
      rd(8'h58, 8'hd0);
      wr(8'h59, 8'h04);
      chk(trim, 8'h5a);
      chk(r7en, 8'hd0);
      chk(r7tr, 8'h04);
      $display("test settings done");
      foreach (ua[j]) begin
         wr(ua[j], 8'hff);
         rd(ua[j], 8'h00);
      end
      $display("test protected done");
      step = 8'hff;
      for (int j = 0; j < 8; j++) fault[j*5] = 1'b1;
      @(posedge clock);
      #1 fault = '0;
      rd(8'h18, 8'hff);
      foreach (fa[j]) rd(fa[j], 8'h03);
      rd(8'h18, 8'h00);
      $display("test fault_summary done");
      stop_test;
   end
endmodule

//--- verification/pmicr_regmap_checker.sv
// Port-level assertions for the register block
`timescale 1ns/1ps
module pmicr_regmap_checker
   import pmicr_pkg::*;
(
   input wire logic                clock,
   input wire logic                reset,
   input wire logic                rate_strap_open,
   input wire logic [4:0]          rate_strap_input,
   input wire logic [4:0]          ramp_strap_code,
   input wire logic                battery_insert_in,
   input wire logic [NSTORE*8-1:0] cfg_image,
   input wire logic [2:0]          primary_switch_rate,
   input wire logic [1:0]          strapped_ramp_time,
   input wire logic                strap_done
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Expected codes from the strap fractions
   function automatic logic [2:0] rate_of(input logic [4:0] v);
      return v >= RT_2000 ? 3'h5 : v >= RT_1750 ? 3'h4 : v >= RT_1500 ? 3'h3 :
             v >= RT_1250 ? 3'h2 : v >= RT_1000 ? 3'h1 : 3'h0;
   endfunction
   function automatic logic [1:0] ramp_of(input logic [4:0] v);
      return v >= SS_32MS ? 2'h3 : v >= SS_8MS ? 2'h2 : v >= SS_2MS ? 2'h1 : 2'h0;
   endfunction
   a_rate_held: assert property (strap_done |=> $stable(primary_switch_rate))
      else $error("rate code moved after startup");
   a_ramp_held: assert property (strap_done |=> $stable(strapped_ramp_time))
      else $error("ramp code moved after startup");
   a_open_default: assert property ($rose(strap_done) && rate_strap_open |->
      primary_switch_rate == 3'h0) else $error("open strap not slowest rate");
   a_rate_decode: assert property ($rose(strap_done) && !rate_strap_open |->
      primary_switch_rate == rate_of(rate_strap_input)) else $error("rate decode wrong");
   a_ramp_decode: assert property ($rose(strap_done) |->
      strapped_ramp_time == ramp_of(ramp_strap_code)) else $error("ramp decode wrong");
   a_ramp_copied: assert property ($rose(strap_done) |-> {cfg_image[105:104],
      cfg_image[129:128], cfg_image[153:152], cfg_image[177:176]} == {4{strapped_ramp_time}})
      else $error("ramp not copied");
   a_cold_flag: assert property ($rose(strap_done) |->
      cfg_image[27] == battery_insert_in) else $error("battery flag wrong");
   a_loop_default: assert property ($fell(reset) |-> cfg_image[183:176] == 8'h78)
      else $error("regulator 8 byte not at default");
   a_unused_zero: assert property (cfg_image[7:0] == 8'h00 &&
      cfg_image[31:29] == 3'h0 && cfg_image[207:201] == 7'h00)
      else $error("unused bits not zero");
endmodule
bind pmicr_regmap pmicr_regmap_checker u_chk (.clock(clock), .reset(reset),
   .rate_strap_open(rate_strap_open), .rate_strap_input(rate_strap_input),
   .ramp_strap_code(ramp_strap_code), .battery_insert_in(battery_insert_in),
   .cfg_image(cfg_image), .primary_switch_rate(primary_switch_rate),
   .strapped_ramp_time(strapped_ramp_time), .strap_done(strap_done));
